// ### hdl/irpw_pkg.sv
// Purpose: Constants and types of the pulse-width infrared receiver
// Assumes: One clock; main oscillator clock is clk
// Notes:   Function
// Function
// - Reset clears control register to zero
// - Receive only while enable bit is set
// - Noise bit picks one or two period filter
// - Prescale bit halves the operating clock
// - Invert bit inverts the receive input
// - Clock field selects source clock tap
// - Error clears shift register and bit counter
// - Full shift register moves to buffer
// - Shift register read after end clears both registers
// - After end, wait for shift register read
// - Disable clears shift, counter and buffer
// - Guide width out of range is discarded
// - Guide width in range raises guide event
// - Short data low raises error, seeks guide
// - Data low in range measures data high
// - Long data low starts end width measurement
// - Bad data high width raises error
// - Data high ranges decode bit 0, 1
// - Overlong high raises error at threshold
// - First bit lands in bit 0
// - End width short is error, else end
// - Filter uses twice or thrice sampled input
// - Errors only after guide, one per guide
package irpw_pkg;
  // ==========================================================
  // Register map
  localparam logic [15:0] IRPW_CTRL_ADDR  = 16'hFF60;
  localparam logic [7:0]  IRPW_CTRL_RESET = 8'h00;
  localparam logic [7:0]  IRPW_CTRL_WMASK = 8'hF3;
  localparam int          IRPW_EN_BIT     = 7;
  localparam int          IRPW_NCW_BIT    = 6;
  localparam int          IRPW_PRS_BIT    = 5;
  localparam int          IRPW_INV_BIT    = 4;
  localparam int          IRPW_CKS_LSB    = 0;
  localparam logic [1:0]  IRPW_CKS_DIV64  = 2'h0;
  localparam logic [1:0]  IRPW_CKS_DIV128 = 2'h1;
  localparam logic [1:0]  IRPW_CKS_DIV256 = 2'h2;
  localparam logic [2:0]  IRPW_LAST_BIT   = 3'h7;
  localparam logic [7:0]  IRPW_CNT_MAX    = 8'hFF;
  localparam int          IRPW_FIFO_DEPTH = 4;

  // ==========================================================
  // State
  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_WRISE = 3'b001,
    S_GUIDE = 3'b010,
    S_DLOW  = 3'b011,
    S_DHIGH = 3'b100,
    S_ENDW  = 3'b101,
    S_HOLD  = 3'b110
  } irpw_state_t;

  typedef struct packed {
    irpw_state_t st;
    logic [7:0]  ctrl;
    logic [7:0]  div;
    logic        sub_prev;
    logic        half;
    logic        sync;
    logic        s1;
    logic        s2;
    logic        s3;
    logic        fin_prev;
    logic [7:0]  cnt;
    logic [7:0]  ecnt;
    logic [7:0]  sr;
    logic [3:0]  scr;
    logic [7:0]  dr;
    logic        gd;
    logic        full;
    logic        done;
    logic        err;
    logic        ovr;
  } irpw_regs_t;
endpackage

// ### hdl/irpw_receiver.sv
// Purpose: Pulse-width infrared receiver with guide pulse, type A
// Assumes: All inputs synchronous to clk; sub_clk sampled as a level
// Notes:   Received bytes also queue in a small FIFO

// ============================================================
// Byte FIFO
module irpw_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int PW = (D > 1) ? $clog2(D) : 1;
  localparam int CW = $clog2(D + 1);
  localparam logic [PW-1:0] PLAST = PW'(D - 1);
  localparam logic [CW-1:0] CFULL = CW'(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [PW-1:0]       wp;
    logic [PW-1:0]       rp;
    logic [CW-1:0]       cnt;
  } irpw_fifo_t;

  irpw_fifo_t q;
  irpw_fifo_t n;
  logic       push;
  logic       pop;

  assign in_ready  = (q.cnt != CFULL);
  assign out_valid = (q.cnt != '0);
  assign out_data  = q.mem[q.rp];

  always_comb begin
    n    = q;
    push = in_valid && in_ready;
    pop  = out_valid && out_ready;
    if (push) begin
      n.mem[q.wp] = in_data;
      n.wp        = (q.wp == PLAST) ? '0 : q.wp + PW'(1);
    end
    if (pop) begin
      n.rp = (q.rp == PLAST) ? '0 : q.rp + PW'(1);
    end
    if (push && !pop) begin
      n.cnt = q.cnt + CW'(1);
    end else if (pop && !push) begin
      n.cnt = q.cnt - CW'(1);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end
endmodule

// ============================================================
// Receiver
module irpw_receiver (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic [15:0] bus_addr,
  input  wire logic       bus_wr,
  input  wire logic [7:0] bus_wdata,
  output logic [7:0]      bus_rdata,
  input  wire logic       sub_clk,
  input  wire logic       serial_receive_input,
  input  wire logic [7:0] guide_short_threshold,
  input  wire logic [7:0] guide_long_threshold,
  input  wire logic [7:0] data_low_short_threshold,
  input  wire logic [7:0] data_low_long_threshold,
  input  wire logic [7:0] data0_short_threshold,
  input  wire logic [7:0] data0_long_threshold,
  input  wire logic [7:0] data1_short_threshold,
  input  wire logic [7:0] data1_long_threshold,
  input  wire logic [7:0] end_width_setting,
  input  wire logic       shift_read,
  output logic [7:0]      receive_shift_register,
  output logic [7:0]      remaining_bit_counter,
  output logic [7:0]      receive_data_buffer,
  output logic            guide_detected_event,
  output logic            buffer_full_event,
  output logic            reception_end_event,
  output logic            reception_error_event,
  output logic            fifo_overrun,
  output logic            byte_valid,
  input  wire logic       byte_ready,
  output logic [7:0]      byte_data
);
  import irpw_pkg::*;

  irpw_regs_t q;
  irpw_regs_t n;
  logic       src;
  logic       tick;
  logic       fin;
  logic       rise;
  logic       fall;
  logic       take;
  logic       bitv;
  logic       fifo_ready;
  logic [7:0] nsr;

  // ==========================================================
  // Outputs
  assign bus_rdata              = (bus_addr == IRPW_CTRL_ADDR) ? q.ctrl : 8'h00;
  assign receive_shift_register = q.sr;
  assign remaining_bit_counter  = {4'h0, q.scr};
  assign receive_data_buffer    = q.dr;
  assign guide_detected_event   = q.gd;
  assign buffer_full_event      = q.full;
  assign reception_end_event    = q.done;
  assign reception_error_event  = q.err;
  assign fifo_overrun           = q.ovr;

  // Overrun is reported, never stalls: the air link cannot wait
  irpw_fifo #(
    .W (8),
    .D (IRPW_FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .arst_n    (arst_n),
    .in_valid  (q.full),
    .in_ready  (fifo_ready),
    .in_data   (q.dr),
    .out_valid (byte_valid),
    .out_ready (byte_ready),
    .out_data  (byte_data)
  );

  // ==========================================================
  // Next state
  always_comb begin
    n      = q;
    src    = 1'b0;
    tick   = 1'b0;
    take   = 1'b0;
    bitv   = 1'b0;
    nsr    = 8'h00;
    n.gd   = 1'b0;
    n.full = 1'b0;
    n.done = 1'b0;
    n.err  = 1'b0;
    n.ovr  = q.full && !fifo_ready;
    n.div  = q.div + 8'h01;
    n.sub_prev = sub_clk;
    if (bus_wr && (bus_addr == IRPW_CTRL_ADDR)) begin
      n.ctrl = bus_wdata & IRPW_CTRL_WMASK;
    end
    case (q.ctrl[IRPW_CKS_LSB +: 2])
      IRPW_CKS_DIV64:  src = &q.div[5:0];
      IRPW_CKS_DIV128: src = &q.div[6:0];
      IRPW_CKS_DIV256: src = &q.div[7:0];
      default:         src = sub_clk && !q.sub_prev;
    endcase
    if (src) begin
      n.half = !q.half;
    end
    tick = src && (!q.ctrl[IRPW_PRS_BIT] || q.half);
    fin  = q.ctrl[IRPW_NCW_BIT] ? q.s3 : q.s2;
    rise = tick && fin && !q.fin_prev;
    fall = tick && !fin && q.fin_prev;
    if (tick) begin
      n.sync     = serial_receive_input ^ q.ctrl[IRPW_INV_BIT];
      n.s1       = q.sync;
      n.fin_prev = fin;
      if (q.sync == q.s1) begin
        n.s2 = q.s1;
      end
      if (q.sync == q.s2) begin
        n.s3 = q.s2;
      end
      if (rise || fall) begin
        n.cnt = 8'h00;
      end else if (q.cnt != IRPW_CNT_MAX) begin
        n.cnt = q.cnt + 8'h01;
      end
      if (q.ecnt != IRPW_CNT_MAX) begin
        n.ecnt = q.ecnt + 8'h01;
      end
    end

    case (q.st)
      S_IDLE: begin
        n.st = S_WRISE;
      end
      S_WRISE: begin
        if (rise) begin
          n.st = S_GUIDE;
        end
      end
      S_GUIDE: begin
        if (fall) begin
          if (q.cnt >= guide_short_threshold && q.cnt < guide_long_threshold) begin
            n.gd = 1'b1;
            n.st = S_DLOW;
          end else begin
            n.st = S_WRISE;
          end
        end
      end
      S_DLOW: begin
        if (rise) begin
          if (q.cnt < data_low_short_threshold) begin
            n.err = 1'b1;
            n.st  = S_GUIDE;
          end else begin
            n.st = S_DHIGH;
          end
        end else if (tick && q.cnt >= data_low_long_threshold) begin
          n.st   = S_ENDW;
          n.ecnt = 8'h00;
        end
      end
      S_DHIGH: begin
        if (fall) begin
          if (q.cnt >= data0_short_threshold && q.cnt < data0_long_threshold) begin
            take = 1'b1;
            bitv = 1'b0;
          end else if (q.cnt >= data1_short_threshold && q.cnt < data1_long_threshold) begin
            take = 1'b1;
            bitv = 1'b1;
          end else begin
            n.err = 1'b1;
            n.st  = S_WRISE;
          end
          if (take) begin
            n.st = S_DLOW;
          end
        end else if (tick && q.cnt >= data1_long_threshold) begin
          n.err = 1'b1;
          n.st  = S_WRISE;
        end
      end
      S_ENDW: begin
        if (rise && q.ecnt < end_width_setting) begin
          n.err = 1'b1;
          n.st  = S_GUIDE;
        end else if (tick && q.ecnt >= end_width_setting) begin
          n.done = 1'b1;
          n.st   = S_HOLD;
        end
      end
      S_HOLD: begin
        if (shift_read) begin
          n.sr  = 8'h00;
          n.scr = 4'h0;
          n.st  = S_WRISE;
        end
      end
      default: begin
        n.st = S_IDLE;
      end
    endcase

    // Newest bit enters at the top, so the first ends in bit 0
    if (take) begin
      nsr = {bitv, q.sr[7:1]};
      if (q.scr[2:0] == IRPW_LAST_BIT) begin
        n.dr   = nsr;
        n.full = 1'b1;
        n.sr   = 8'h00;
        n.scr  = 4'h0;
      end else begin
        n.sr  = nsr;
        n.scr = q.scr + 4'h1;
      end
    end
    if (n.err) begin
      n.sr  = 8'h00;
      n.scr = 4'h0;
    end
    if (!q.ctrl[IRPW_EN_BIT]) begin
      n.st   = S_IDLE;
      n.sr   = 8'h00;
      n.scr  = 4'h0;
      n.dr   = 8'h00;
      n.gd   = 1'b0;
      n.full = 1'b0;
      n.done = 1'b0;
      n.err  = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q      <= '0;
      q.ctrl <= IRPW_CTRL_RESET;
    end else begin
      q <= n;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  property p_disabled_idle;
    !q.ctrl[IRPW_EN_BIT] |=> (q.st == S_IDLE) && !q.gd && !q.err;
  endproperty
  a_disabled_idle: assert property (p_disabled_idle) else $error("active while disabled");

  property p_disable_clears;
    !q.ctrl[IRPW_EN_BIT] |=> (q.sr == 8'h00) && (q.scr == 4'h0) && (q.dr == 8'h00);
  endproperty
  a_disable_clears: assert property (p_disable_clears) else $error("disable left data");

  property p_err_clears;
    q.err |-> (q.sr == 8'h00) && (q.scr == 4'h0);
  endproperty
  a_err_clears: assert property (p_err_clears) else $error("error kept shift data");

  property p_full_moves;
    q.full |-> (q.sr == 8'h00) && (q.scr == 4'h0) && ($past(q.scr) == 4'h7);
  endproperty
  a_full_moves: assert property (p_full_moves) else $error("bad byte transfer");

  property p_hold_waits;
    (q.st == S_HOLD) && q.ctrl[IRPW_EN_BIT] && !shift_read |=> (q.st == S_HOLD);
  endproperty
  a_hold_waits: assert property (p_hold_waits) else $error("left hold unread");

  property p_read_clears;
    (q.st == S_HOLD) && q.ctrl[IRPW_EN_BIT] && shift_read |=>
      (q.sr == 8'h00) && (q.scr == 4'h0) && (q.st == S_WRISE);
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("read did not clear");

  property p_guide_next;
    q.gd |-> (q.st == S_DLOW) && ($past(q.st) == S_GUIDE);
  endproperty
  a_guide_next: assert property (p_guide_next) else $error("guide event misplaced");

  property p_end_hold;
    q.done |-> (q.st == S_HOLD) && ($past(q.st) == S_ENDW);
  endproperty
  a_end_hold: assert property (p_end_hold) else $error("end without hold");

  property p_err_after_guide;
    q.err |-> ($past(q.st) inside {S_DLOW, S_DHIGH, S_ENDW}) && (q.st inside {S_WRISE, S_GUIDE});
  endproperty
  a_err_after_guide: assert property (p_err_after_guide) else $error("error before guide");

  c_guide: cover property (q.gd);
  c_full:  cover property (q.full);
  c_end:   cover property (q.done ##[1:200] shift_read);
  c_err:   cover property (q.err);
endmodule

// ### tb/irpw_ir_model.sv
// Purpose: Behavioural infrared sender on the receive pin
// Assumes: Widths in operating ticks of tick_cyc clk cycles
// Notes:   Edges land just after a rising clk edge
module irpw_ir_model (
  input  wire logic clk,
  output logic      line
);
  timeunit 1ns;
  timeprecision 1ps;
  int   tick_cyc = 64;
  logic inv      = 1'b0;
  initial line = 1'b0;

  // ========
  // Waveform pieces
  // Whole ticks only, so measured count is exact
  task automatic lvl(input logic v, input int n);
    line <= v ^ inv;
    repeat (n * tick_cyc) @(posedge clk);
  endtask

  // Data low then high, bit 1 high twice as long
  task automatic bitx(input logic b);
    lvl(1'b0, 3);
    lvl(1'b1, b ? 8 : 4);
  endtask
endmodule

// ### tb/tb_top.sv
// Purpose: Self-checking bench of the infrared receiver
// Assumes: Thresholds static; sub_clk period 64 clk
// Notes:   Frames built by the sender model
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import irpw_pkg::*;
  logic clk, arst_n, bus_wr, sub_clk, rx, shift_read, byte_ready;
  logic [15:0] bus_addr;
  logic [7:0] bus_wdata, bus_rdata, sr, scr, dr, byte_data;
  logic gd, full, done, err, ovr, byte_valid;
  logic [7:0] gs, gl, dls, dll, d0s, d0l, d1s, d1l, ew;
  logic [5:0] sub_div = 6'h00;
  int n_gd, n_full, n_end, n_err, n_ov;
  int fail_count = 0;
  int n_tests = 0;
  logic [7:0] cfg [6] = '{8'h81, 8'h82, 8'h83, 8'hA0, 8'h90, 8'hC0};
  int tcs [6] = '{128, 256, 64, 128, 64, 64};
  int nbs [6] = '{8, 0, 8, 8, 8, 11};

  irpw_ir_model ir (.clk(clk), .line(rx));
  irpw_receiver uut (
    .clk(clk), .arst_n(arst_n), .bus_addr(bus_addr), .bus_wr(bus_wr),
    .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .sub_clk(sub_clk),
    .serial_receive_input(rx), .guide_short_threshold(gs),
    .guide_long_threshold(gl), .data_low_short_threshold(dls),
    .data_low_long_threshold(dll), .data0_short_threshold(d0s),
    .data0_long_threshold(d0l), .data1_short_threshold(d1s),
    .data1_long_threshold(d1l), .end_width_setting(ew),
    .shift_read(shift_read), .receive_shift_register(sr),
    .remaining_bit_counter(scr), .receive_data_buffer(dr),
    .guide_detected_event(gd), .buffer_full_event(full),
    .reception_end_event(done), .reception_error_event(err),
    .fifo_overrun(ovr), .byte_valid(byte_valid), .byte_ready(byte_ready),
    .byte_data(byte_data));

  // ========
  // Clock, subsystem clock, event counts
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    sub_div <= sub_div + 6'h01;
    sub_clk <= sub_div[5];
    n_gd += (gd === 1'b1);
    n_full += (full === 1'b1);
    n_end += (done === 1'b1);
    n_err += (err === 1'b1);
    n_ov += (ovr === 1'b1);
  end

  // ========
  // Tasks
  task conclude();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge clk);
    bus_addr <= a;
    bus_wdata <= v;
    bus_wr <= 1'b1;
    @(posedge clk);
    bus_wr <= 1'b0;
    @(posedge clk) #1;
  endtask
  task rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk) bus_addr <= a;
    @(posedge clk) #1;
    chk("ctrl", e, bus_rdata);
  endtask
  task clr();
    n_gd = 0;
    n_full = 0;
    n_end = 0;
    n_err = 0;
    n_ov = 0;
  endtask
  task start(input logic [7:0] c, input int tc);
    wr(IRPW_CTRL_ADDR, 8'h00);
    chk("buffer", 8'h00, dr);
    ir.tick_cyc = tc;
    ir.inv = c[4];
    ir.lvl(1'b0, 1);
    wr(IRPW_CTRL_ADDR, c);
    ir.lvl(1'b0, 4);
    clr();
  endtask
  task pop(input logic [7:0] e);
    int n;
    n = 0;
    while (byte_valid !== 1'b1 && n < 16) begin
      @(posedge clk) #1;
      n++;
    end
    if (n == 16) begin
      fail_count++;
      conclude();
    end
    chk("fifo", e, byte_data);
    @(posedge clk) byte_ready <= 1'b1;
    @(posedge clk) byte_ready <= 1'b0;
    @(posedge clk) #1;
  endtask
  // Guide, nb bits first-bit-first, long end low
  task automatic frame(input logic [7:0] c, input int tc, input int nb,
                       input logic [39:0] d);
    int r;
    logic [7:0] e;
    start(c, tc);
    ir.lvl(1'b1, 9);
    for (int i = 0; i < nb; i++) ir.bitx(d[i]);
    ir.lvl(1'b0, 20);
    r = nb % 8;
    e = 8'h00;
    for (int k = 0; k < r; k++) e[8 - r + k] = d[nb - r + k];
    chk("end", 8'h01, n_end[7:0]);
    chk("full", 8'(nb / 8), n_full[7:0]);
    chk("error", 8'h00, n_err[7:0]);
    chk("count", 8'(r), scr);
    chk("shift", e, sr);
    if (nb >= 8) chk("buffer", d[8*(nb/8)-8 +: 8], dr);
    if (tc == 64) begin
      ir.lvl(1'b1, 9);
      ir.lvl(1'b0, 4);
    end
    chk("guide", 8'h01, n_gd[7:0]);
    @(posedge clk) shift_read <= 1'b1;
    @(posedge clk) shift_read <= 1'b0;
    @(posedge clk) #1;
    chk("count", 8'h00, scr);
    chk("shift", 8'h00, sr);
  endtask

  // ========
  // Main sequence
  initial begin
    arst_n = 1'b0;
    bus_addr = IRPW_CTRL_ADDR;
    bus_wr = 1'b0;
    bus_wdata = 8'h00;
    shift_read = 1'b0;
    byte_ready = 1'b0;
    sub_clk = 1'b0;
    gs = 8'h06;
    gl = 8'h0A;
    dls = 8'h01;
    dll = 8'h04;
    d0s = 8'h02;
    d0l = 8'h05;
    d1s = 8'h06;
    d1l = 8'h09;
    ew = 8'h03;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    rd(IRPW_CTRL_ADDR, IRPW_CTRL_RESET);
    wr(IRPW_CTRL_ADDR, 8'h73);
    rd(IRPW_CTRL_ADDR, 8'h73);
    wr(16'hFF61, 8'h55);
    rd(16'hFF61, 8'h00);
    rd(IRPW_CTRL_ADDR, 8'h73);
    // Reader stalled: five bytes into four slots
    frame(8'h80, 64, 40, 40'h96_3C_A5_5A_C3);
    chk("overrun", 8'h01, n_ov[7:0]);
    pop(8'hC3);
    pop(8'h5A);
    pop(8'hA5);
    pop(8'h3C);
    chk("valid", 8'h00, {7'h00, byte_valid});
    byte_ready <= 1'b1;
    for (int i = 0; i < 6; i++) frame(cfg[i], tcs[i], nbs[i], 40'h6B5);
    // Too-short guide, then bad data high
    start(8'h80, 64);
    ir.lvl(1'b1, 3);
    ir.lvl(1'b0, 5);
    chk("guide", 8'h00, n_gd[7:0]);
    chk("error", 8'h00, n_err[7:0]);
    ir.lvl(1'b1, 9);
    ir.bitx(1'b1);
    ir.bitx(1'b0);
    ir.lvl(1'b0, 3);
    ir.lvl(1'b1, 2);
    ir.lvl(1'b0, 20);
    chk("guide", 8'h01, n_gd[7:0]);
    chk("error", 8'h01, n_err[7:0]);
    chk("end", 8'h00, n_end[7:0]);
    chk("count", 8'h00, scr);
    chk("shift", 8'h00, sr);
    conclude();
  end
endmodule
